/* File: tctt_channel.sv */
// Purpose: One 8-bit compare channel with toggle output
// Assumes: Tick from the prescaler, software load strobes
// Notes: Software writes win over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tctt_channel
    import tctt_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Count control
    input wire logic tick,
    input wire logic clr_on_match,
    // Software access
    input wire logic cnt_wr,
    input wire logic [WIDTH-1:0] cnt_wdata,
    input wire logic [WIDTH-1:0] cmp_val,
    input wire logic lvl_load,
    input wire logic lvl_val,
    // Results
    output logic [WIDTH-1:0] cnt,
    output logic toggle_out,
    output logic match_ev,
    output logic ovf_ev
);
    // ------------------------------------------------------------
    // Counter and toggle
    // ------------------------------------------------------------
    logic [WIDTH-1:0] cnt_q;     // Up-counter
    logic [WIDTH-1:0] cnt_d;
    logic tog_q;                 // Toggle output level
    logic tog_d;
    logic match;
    logic top;

    assign match = tick && (cnt_q == cmp_val);
    assign top = tick && (cnt_q == {WIDTH{1'b1}});
    assign match_ev = match;
    assign ovf_ev = top && !(match && clr_on_match);
    // Next count: write, clear on match, or step
    assign cnt_d = cnt_wr ? cnt_wdata :
                   (match && clr_on_match) ? '0 :
                   tick ? cnt_q + 1'b1 : cnt_q;
    // Preset wins, else invert on match
    assign tog_d = lvl_load ? lvl_val :
                   match ? !tog_q : tog_q;
    assign cnt = cnt_q;
    assign toggle_out = tog_q;

    // State update
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= '0;
            tog_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tog_q <= tog_d;
        end
    end
endmodule
`default_nettype wire

/* File: tctt_monitor.sv */
// Purpose: Concurrent checks on the tone timer register port and pins
// Assumes: One ref_clk domain, srst synchronous active high
// Notes: Shadows control and mask writes to judge pin behaviour
`timescale 1ns/1ps
`default_nettype none
module tctt_monitor
    import tctt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic low_toggle_output,
    input wire logic high_toggle_output,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    logic [7:0] ctrl_q; // Last control write
    logic [7:0] mask_q; // Last mask write
    wire logic ctrl_wr = reg_wr && (reg_addr == TCTT_ADDR_CTRL); // Control write
    wire logic stop_wr = ctrl_wr && (reg_wdata[TCTT_CTRL_CKS_LO +: 2] == TCTT_CKS_STOP); // Write that halts ticks
    wire logic load_lo = stop_wr && reg_wdata[TCTT_CTRL_LOAD_LO]; // Halting write with low preset
    wire logic load_hi = stop_wr && reg_wdata[TCTT_CTRL_LOAD_HI]; // Halting write with high preset
    wire logic keep_wr = stop_wr && !reg_wdata[TCTT_CTRL_LOAD_LO] && !reg_wdata[TCTT_CTRL_LOAD_HI]; // No preset
    wire logic halted = (ctrl_q[TCTT_CTRL_CKS_LO +: 2] == TCTT_CKS_STOP); // Ticks stopped
    wire logic lvl_lo = reg_wdata[TCTT_CTRL_LVL_LO]; // Low preset level
    wire logic lvl_hi = reg_wdata[TCTT_CTRL_LVL_HI]; // High preset level
    // Follow control and mask writes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= 8'h00;
            mask_q <= 8'h00;
        end else begin
            if (ctrl_wr) ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == TCTT_ADDR_IRQ_MSK) mask_q <= reg_wdata;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Counter write while halted, read two cycles on
    sequence cnt_wr_then_rd;
        reg_wr && reg_addr == TCTT_ADDR_CNT_LO && halted ##2 reg_rd && reg_addr == TCTT_ADDR_CNT_LO;
    endsequence
    AST_CTRL_READS_ZERO: assert property (reg_rd && reg_addr == TCTT_ADDR_CTRL |=> reg_rdata == 8'h00)
        else $error("control register read gave nonzero data");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_CNT_READBACK: assert property (cnt_wr_then_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("halted low counter did not read back");
    AST_PRESET_LO: assert property (load_lo |-> ##2 low_toggle_output == $past(lvl_lo, 2))
        else $error("low toggle preset not applied");
    AST_PRESET_HI: assert property (load_hi |-> ##2 high_toggle_output == $past(lvl_hi, 2))
        else $error("high toggle preset not applied");
    AST_STOP_HOLDS: assert property (keep_wr |-> ##3
        $stable(low_toggle_output) && $stable(high_toggle_output))
        else $error("toggle moved while ticks halted");
    AST_MASK_CLEARS_IRQ: assert property (reg_wr && reg_addr == TCTT_ADDR_IRQ_MSK && reg_wdata == 8'h00 |=> !irq)
        else $error("irq stayed high after full mask");
    AST_IRQ_NEEDS_MASK: assert property (irq |-> mask_q != 8'h00)
        else $error("irq high with every source masked");
    // Main scenarios reached
    COV_IRQ: cover property ($rose(irq));
    COV_LOW_TOGGLE: cover property ($changed(low_toggle_output));
    COV_HIGH_TOGGLE: cover property ($changed(high_toggle_output));
endmodule
bind tctt_top tctt_monitor u_tctt_monitor (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_toggle_output(low_toggle_output), .high_toggle_output(high_toggle_output), .irq(irq));
`default_nettype wire

/* File: tctt_pkg.sv */
// Purpose: Constants and types for the toggle compare tone timer
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes: Register offsets and bit positions are local to this block
//
// Functional notes
// - Counter steps once per selected clock tick
// - Compare each count; clear, interrupt, toggle
// - Two independent 8-bit timers, low and high
// - Software presets each toggle output level
// - Prescaler gives clock over 32, 16, 4
// - Write-only control selects clock, low and high levels
// - Both counters readable and writable up-counters
// - Status register gates clear and overflow interrupt
// - Low match toggles, sets flag, interrupts together
// - Stored compare value reused every cycle
package tctt_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] TCTT_ADDR_CTRL = 4'h0;      // Clock select and levels, write only
    localparam logic [3:0] TCTT_ADDR_STAT = 4'h1;      // Control and status
    localparam logic [3:0] TCTT_ADDR_CNT_LO = 4'h2;    // Low counter
    localparam logic [3:0] TCTT_ADDR_CNT_HI = 4'h3;    // High counter
    localparam logic [3:0] TCTT_ADDR_CMP_LO = 4'h4;    // Low compare value
    localparam logic [3:0] TCTT_ADDR_CMP_HI = 4'h5;    // High compare value
    localparam logic [3:0] TCTT_ADDR_IRQ_ST = 4'h6;    // Sticky events, read clears
    localparam logic [3:0] TCTT_ADDR_IRQ_MSK = 4'h7;   // Interrupt mask
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int TCTT_CTRL_LVL_LO = 0;               // Low toggle preset level
    localparam int TCTT_CTRL_LVL_HI = 1;               // High toggle preset level
    localparam int TCTT_CTRL_LOAD_LO = 2;              // Apply low preset when set
    localparam int TCTT_CTRL_LOAD_HI = 3;              // Apply high preset when set
    localparam int TCTT_CTRL_CKS_LO = 4;               // Clock select field, two bits
    // ------------------------------------------------------------
    // Status and event fields
    // ------------------------------------------------------------
    localparam int TCTT_ST_CCLR_LO = 0;                // Low match clears counter
    localparam int TCTT_ST_CCLR_HI = 1;                // High match clears counter
    localparam int TCTT_ST_OVIE_LO = 2;                // Low overflow interrupt enable
    localparam int TCTT_ST_OVIE_HI = 3;                // High overflow interrupt enable
    localparam int TCTT_ST_CMIE_LO = 4;                // Low match interrupt enable
    localparam int TCTT_ST_CMIE_HI = 5;                // High match interrupt enable
    localparam int TCTT_EV_CM_LO = 0;                  // Low match event
    localparam int TCTT_EV_CM_HI = 1;                  // High match event
    localparam int TCTT_EV_OV_LO = 2;                  // Low overflow event
    localparam int TCTT_EV_OV_HI = 3;                  // High overflow event
    // ------------------------------------------------------------
    // Reset values and prescale divisors
    // ------------------------------------------------------------
    localparam logic [7:0] TCTT_RST_STAT = 8'h03;      // Clear on match by default
    localparam logic [7:0] TCTT_RST_CMP = 8'hFF;       // Compare at top by default
    localparam logic [7:0] TCTT_RST_BYTE = 8'h00;      // Generic zero
    localparam int TCTT_DIV_A = 32;
    localparam int TCTT_DIV_B = 16;
    localparam int TCTT_DIV_C = 4;
    localparam int TCTT_PRE_W = 5;                     // Prescaler counter width
    // Clock select codes
    typedef enum logic [1:0] {
        TCTT_CKS_DIV32 = 2'h0,
        TCTT_CKS_DIV16 = 2'h1,
        TCTT_CKS_DIV4 = 2'h2,
        TCTT_CKS_STOP = 2'h3
    } tctt_cks_t;
endpackage

/* File: tctt_prescaler.sv */
// Purpose: Free running divider giving tick pulses
// Assumes: One clock, synchronous reset
// Notes: Ticks are one cycle pulses, not clocks
`timescale 1ns/1ps
`default_nettype none
module tctt_prescaler
    import tctt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Selected tick
    input wire tctt_cks_t cks,
    output logic tick
);
    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    logic [TCTT_PRE_W-1:0] pre_q;  // Free running count
    logic [TCTT_PRE_W-1:0] pre_d;
    logic tick_a;
    logic tick_b;
    logic tick_c;

    assign pre_d = pre_q + 5'h01;
    // Each tap fires when its low bits all are ones
    assign tick_a = (pre_q[4:0] == 5'(TCTT_DIV_A - 1));
    assign tick_b = (pre_q[3:0] == 4'(TCTT_DIV_B - 1));
    assign tick_c = (pre_q[1:0] == 2'(TCTT_DIV_C - 1));
    // Tap select
    assign tick = (cks == TCTT_CKS_DIV32) ? tick_a :
                  (cks == TCTT_CKS_DIV16) ? tick_b :
                  (cks == TCTT_CKS_DIV4) ? tick_c : 1'b0;

    // Count step
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre_q <= 5'h00;
        end else begin
            pre_q <= pre_d;
        end
    end
endmodule
`default_nettype wire

/* File: tctt_top.sv */
// Purpose: Toggle compare tone timer with register port
// Assumes: 125 MHz ref_clk, synchronous active high reset
// Notes: Read data valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module tctt_top
    import tctt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Tone outputs
    output logic low_toggle_output,
    output logic high_toggle_output,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] timer_clock_and_level_control_q;  // Write only control
    logic [7:0] timer_control_status_q;           // Control and status
    logic [7:0] low_compare_value_q;              // Low compare value
    logic [7:0] high_compare_value_q;             // High compare value
    logic [3:0] irq_stat_q;                       // Sticky events
    logic [3:0] irq_stat_d;
    logic [3:0] irq_mask_q;                       // Event mask
    logic [7:0] rdata_q;                          // Read data
    logic [7:0] rdata_d;
    logic lvl_load_lo_q;                          // One cycle preset strobes
    logic lvl_load_hi_q;
    // Decode wires
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_cmp_lo;
    logic wr_cmp_hi;
    logic wr_mask;
    logic rd_irq;
    // Channel wires
    logic tick;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic cm_lo;
    logic cm_hi;
    logic ov_lo;
    logic ov_hi;
    logic [3:0] ev;
    logic [3:0] ev_en;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == TCTT_ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == TCTT_ADDR_STAT);
    assign wr_cnt_lo = reg_wr && (reg_addr == TCTT_ADDR_CNT_LO);
    assign wr_cnt_hi = reg_wr && (reg_addr == TCTT_ADDR_CNT_HI);
    assign wr_cmp_lo = reg_wr && (reg_addr == TCTT_ADDR_CMP_LO);
    assign wr_cmp_hi = reg_wr && (reg_addr == TCTT_ADDR_CMP_HI);
    assign wr_mask = reg_wr && (reg_addr == TCTT_ADDR_IRQ_MSK);
    assign rd_irq = reg_rd && (reg_addr == TCTT_ADDR_IRQ_ST);

    // Read mux; control register reads as zero
    always_comb begin
        if (reg_addr == TCTT_ADDR_STAT) begin
            rdata_d = timer_control_status_q;
        end else if (reg_addr == TCTT_ADDR_CNT_LO) begin
            rdata_d = cnt_lo;
        end else if (reg_addr == TCTT_ADDR_CNT_HI) begin
            rdata_d = cnt_hi;
        end else if (reg_addr == TCTT_ADDR_CMP_LO) begin
            rdata_d = low_compare_value_q;
        end else if (reg_addr == TCTT_ADDR_CMP_HI) begin
            rdata_d = high_compare_value_q;
        end else if (reg_addr == TCTT_ADDR_IRQ_ST) begin
            rdata_d = {4'h0, irq_stat_q};
        end else if (reg_addr == TCTT_ADDR_IRQ_MSK) begin
            rdata_d = {4'h0, irq_mask_q};
        end else begin
            rdata_d = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Prescaler and channels
    // ------------------------------------------------------------
    tctt_prescaler u_pre (
        .ref_clk(ref_clk),
        .srst(srst),
        .cks(tctt_cks_t'(timer_clock_and_level_control_q[TCTT_CTRL_CKS_LO +: 2])),
        .tick(tick)
    );

    // Low channel
    tctt_channel #(.WIDTH(8)) u_lo (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(tick),
        .clr_on_match(timer_control_status_q[TCTT_ST_CCLR_LO]),
        .cnt_wr(wr_cnt_lo),
        .cnt_wdata(reg_wdata),
        .cmp_val(low_compare_value_q),
        .lvl_load(lvl_load_lo_q),
        .lvl_val(timer_clock_and_level_control_q[TCTT_CTRL_LVL_LO]),
        .cnt(cnt_lo),
        .toggle_out(low_toggle_output),
        .match_ev(cm_lo),
        .ovf_ev(ov_lo)
    );

    // High channel
    tctt_channel #(.WIDTH(8)) u_hi (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(tick),
        .clr_on_match(timer_control_status_q[TCTT_ST_CCLR_HI]),
        .cnt_wr(wr_cnt_hi),
        .cnt_wdata(reg_wdata),
        .cmp_val(high_compare_value_q),
        .lvl_load(lvl_load_hi_q),
        .lvl_val(timer_clock_and_level_control_q[TCTT_CTRL_LVL_HI]),
        .cnt(cnt_hi),
        .toggle_out(high_toggle_output),
        .match_ev(cm_hi),
        .ovf_ev(ov_hi)
    );

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign ev = {ov_hi, ov_lo, cm_hi, cm_lo};
    // Enables from the status register gate event capture
    assign ev_en = {timer_control_status_q[TCTT_ST_OVIE_HI],
                    timer_control_status_q[TCTT_ST_OVIE_LO],
                    timer_control_status_q[TCTT_ST_CMIE_HI],
                    timer_control_status_q[TCTT_ST_CMIE_LO]};
    // Set wins over read clear
    assign irq_stat_d = (rd_irq ? 4'h0 : irq_stat_q) | (ev & ev_en);
    assign irq = |(irq_stat_q & irq_mask_q);
    assign reg_rdata = rdata_q;

    // Control registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer_clock_and_level_control_q <= TCTT_RST_BYTE;
            timer_control_status_q <= TCTT_RST_STAT;
            low_compare_value_q <= TCTT_RST_CMP;
            high_compare_value_q <= TCTT_RST_CMP;
            irq_mask_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                timer_clock_and_level_control_q <= reg_wdata;
            end
            if (wr_stat) begin
                timer_control_status_q <= reg_wdata;
            end
            if (wr_cmp_lo) begin
                low_compare_value_q <= reg_wdata;
            end
            if (wr_cmp_hi) begin
                high_compare_value_q <= reg_wdata;
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[3:0];
            end
        end
    end

    // Preset strobes, status and read data
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lvl_load_lo_q <= 1'b0;
            lvl_load_hi_q <= 1'b0;
            irq_stat_q <= 4'h0;
            rdata_q <= 8'h00;
        end else begin
            lvl_load_lo_q <= wr_ctrl && reg_wdata[TCTT_CTRL_LOAD_LO];
            lvl_load_hi_q <= wr_ctrl && reg_wdata[TCTT_CTRL_LOAD_HI];
            irq_stat_q <= irq_stat_d;
            rdata_q <= reg_rd ? rdata_d : 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: tctt_top_tb.sv */
// Purpose: Self-checking bench for the toggle compare tone timer
// Assumes: 125 MHz ref_clk, one idle cycle after every transfer
// Notes: Tick phase is unknown, so waits are bounded polls
`timescale 1ns/1ps
`default_nettype none
module tctt_top_tb
    import tctt_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------
    logic ref_clk = 1'b0; // Bench clock
    logic srst = 1'b1; // Held high at start
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic low_toggle_output;
    logic high_toggle_output;
    logic irq;
    logic [7:0] q; // Last read answer
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0; // Hang guard
    int n;
    tctt_top dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_toggle_output(low_toggle_output),
        .high_toggle_output(high_toggle_output), .irq(irq));
    // 8 ns period
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One write or read, strobe for one cycle, answer sampled after
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        xfer(1'b0, a, 8'h00);
        chk(what, q, exp);
    endtask
    // Cycles until the chosen toggle pin changes
    task automatic wait_edge(input int ch, output int cyc);
        logic v;
        v = ch ? high_toggle_output : low_toggle_output;
        cyc = 0;
        do begin
            @(posedge ref_clk);
            #1 cyc++;
        end while ((ch ? high_toggle_output : low_toggle_output) === v && cyc < 300);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        int k;
        int d;
        int cmp;
        logic [7:0] pre_d [3]; // Preset writes, all halted
        logic [7:0] pre_e [3]; // Pin levels, high then low
        pre_d = '{8'h3F, 8'h3C, 8'h37};
        pre_e = '{8'h03, 8'h00, 8'h01};
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        // Reset values, write-only control, unmapped place
        rd_chk(TCTT_ADDR_STAT, 8'h03, "stat_reset");
        rd_chk(TCTT_ADDR_CMP_LO, 8'hFF, "cmp_lo_reset");
        rd_chk(TCTT_ADDR_CMP_HI, 8'hFF, "cmp_hi_reset");
        rd_chk(TCTT_ADDR_CTRL, 8'h00, "ctrl_read");
        xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'h0F);
        rd_chk(TCTT_ADDR_IRQ_MSK, 8'h0F, "mask_rw");
        xfer(1'b1, 4'h8, 8'hAA);
        rd_chk(4'h8, 8'h00, "unmapped");
        xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'h00);
        $display("test reset_map done");
        // Counters read and write while halted
        xfer(1'b1, TCTT_ADDR_CTRL, 8'h30);
        xfer(1'b1, TCTT_ADDR_CNT_LO, 8'h5A);
        rd_chk(TCTT_ADDR_CNT_LO, 8'h5A, "cnt_lo_rw");
        xfer(1'b1, TCTT_ADDR_CNT_HI, 8'hA5);
        rd_chk(TCTT_ADDR_CNT_HI, 8'hA5, "cnt_hi_rw");
        repeat (40) @(posedge ref_clk);
        rd_chk(TCTT_ADDR_CNT_LO, 8'h5A, "cnt_halted");
        $display("test counters done");
        // Eight ticks in exactly eight divider periods, each divisor
        for (k = 0; k < 3; k++) begin
            d = (k == 0) ? TCTT_DIV_A : (k == 1) ? TCTT_DIV_B : TCTT_DIV_C;
            xfer(1'b1, TCTT_ADDR_CNT_LO, 8'h00);
            xfer(1'b1, TCTT_ADDR_CNT_HI, 8'h00);
            xfer(1'b1, TCTT_ADDR_CTRL, {2'h0, k[1:0], 4'h0});
            repeat (8 * d - 2) @(posedge ref_clk);
            xfer(1'b1, TCTT_ADDR_CTRL, 8'h30);
            rd_chk(TCTT_ADDR_CNT_LO, 8'h08, "lo_ticks");
            rd_chk(TCTT_ADDR_CNT_HI, 8'h08, "hi_ticks");
        end
        $display("test prescaler done");
        // Preset levels, both pins and low only
        for (i = 0; i < 3; i++) begin
            xfer(1'b1, TCTT_ADDR_CTRL, pre_d[i]);
            repeat (2) @(posedge ref_clk);
            #1 chk("preset", {6'h00, high_toggle_output, low_toggle_output}, pre_e[i]);
        end
        $display("test preset done");
        // Match toggles with clear, irq raised, masked, read cleared
        for (k = 0; k < 2; k++) begin
            cmp = k ? 1 : 3;
            xfer(1'b1, TCTT_ADDR_STAT, k ? 8'h22 : 8'h11);
            xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'(1 << k));
            xfer(1'b1, 4'(TCTT_ADDR_CMP_LO + k), 8'(cmp));
            xfer(1'b1, 4'(TCTT_ADDR_CNT_LO + k), 8'h00);
            xfer(1'b0, TCTT_ADDR_IRQ_ST, 8'h00);
            xfer(1'b1, TCTT_ADDR_CTRL, 8'h20);
            wait_edge(k, n);
            chk("irq_with_toggle", {7'h00, irq}, 8'h01);
            for (i = 0; i < 2; i++) begin
                wait_edge(k, n);
                chk("half_period", 8'(n), 8'(TCTT_DIV_C * (cmp + 1)));
            end
            xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'h00);
            chk("irq_masked", {7'h00, irq}, 8'h00);
            xfer(1'b1, TCTT_ADDR_CTRL, 8'h30);
            rd_chk(TCTT_ADDR_IRQ_ST, 8'(1 << k), "match_event");
            xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'(1 << k));
            chk("irq_read_clear", {7'h00, irq}, 8'h00);
        end
        $display("test match done");
        // No clear on match: both counters pass compare and wrap together
        xfer(1'b1, TCTT_ADDR_STAT, 8'h0C);
        xfer(1'b1, TCTT_ADDR_IRQ_MSK, 8'h0C);
        xfer(1'b1, TCTT_ADDR_CNT_LO, 8'h00);
        xfer(1'b1, TCTT_ADDR_CNT_HI, 8'h00);
        xfer(1'b1, TCTT_ADDR_CTRL, 8'h20);
        n = 0;
        while (irq !== 1'b1 && n < 1100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        xfer(1'b1, TCTT_ADDR_CTRL, 8'h30);
        chk("ovf_irq", {7'h00, irq}, 8'h01);
        rd_chk(TCTT_ADDR_IRQ_ST, 8'h0C, "ovf_event");
        chk("ovf_read_clear", {7'h00, irq}, 8'h00);
        xfer(1'b0, TCTT_ADDR_CNT_LO, 8'h00);
        chk("wrapped", 8'(q < 8'h08), 8'h01);
        xfer(1'b0, TCTT_ADDR_CNT_HI, 8'h00);
        chk("wrapped_hi", 8'(q < 8'h08), 8'h01);
        $display("test overflow done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
